// ===== rtl/fgc_config_word.sv
// configuration word register bank of the fuel gauge
//
// Behaviour
// - bit 10 enables direction-change interrupt
// - bit 9 holds soft shutdown while set
// - writing bit 8 clears both tallies
// - writing bit 7 clears four status flags
// - bit 6 picks charge or discharge tally
// - bit 5 grounds sense input internally
// - calibration mode stops both tallies counting
// - overcurrent detection stays on during calibration
// - bit 4 enables compare and its interrupt
// - bits 3:2 drive discharge switch; keep 2 low
// - bits 1:0 drive charge switch; keep 0 low
// - powerdown pin low holds hard shutdown
// - status select echo mirrors bit 6
// - soft shutdown also clears flow reversal flag
`timescale 1ns/1ps
module fgc_config_word (
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_n,
  // configuration word write from the serial link decoder
  input  wire logic                      i_cfg_wr,
  input  wire logic [fgc_pkg::CFG_W-1:0] i_cfg_data,
  // powerdown pin, asynchronous
  input  wire logic                      i_powerdown_pin_n,
  // events from the sense front end and comparator logic
  input  wire logic                      i_tally_charge_inc,
  input  wire logic                      i_tally_discharge_inc,
  input  wire logic                      i_discharge_overcurrent,
  input  wire logic                      i_charge_overcurrent,
  input  wire logic                      i_compare_match,
  input  wire logic                      i_flow_reversal,
  // controls to the analog side
  output logic                           o_zero_cal_ground,
  output logic                           o_soft_powerdown,
  output logic                           o_hard_powerdown,
  output logic                           o_compare_enable,
  output logic [1:0]                     o_discharge_switch_drive,
  output logic [1:0]                     o_charge_switch_drive,
  // read path
  output logic [fgc_pkg::TALLY_W-1:0]    o_tally_read,
  output fgc_pkg::fgc_flags_t            o_flags,
  output logic                           o_tally_select_echo,
  output logic                           o_irq
);
  import fgc_pkg::*;

  fgc_cfg_t               cfg_q;
  logic                   clr_tallies_q;
  logic                   clr_irq_q;
  logic [1:0]             pd_sync_q;
  logic                   hard_pd_q;
  logic [TALLY_W-1:0]     chg_tally_q;
  logic [TALLY_W-1:0]     dis_tally_q;
  logic [TALLY_W-1:0]     tally_read_q;
  logic                   echo_q;
  logic                   irq_q;
  logic                   soft_pd_out_q;
  logic                   zero_cal_q;
  logic                   cmp_en_q;
  logic [1:0]             dis_drive_q;
  logic [1:0]             chg_drive_q;
  logic [3:0]             flag_set;
  logic [3:0]             flag_clr;
  logic [3:0]             flag_val;
  logic                   counting;

  // ==========================================================
  // configuration word storage; bits 15:11 have no storage
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cfg_q <= '0;
    end else if (i_cfg_wr) begin
      cfg_q.direction_irq_enable   <= i_cfg_data[BIT_DIR_IRQ_EN];
      cfg_q.soft_powerdown         <= i_cfg_data[BIT_SOFT_PD];
      cfg_q.tally_select           <= i_cfg_data[BIT_TALLY_SEL];
      cfg_q.input_zero_calibration <= i_cfg_data[BIT_ZERO_CAL];
      cfg_q.compare_irq_enable     <= i_cfg_data[BIT_CMP_IRQ_EN];
      cfg_q.discharge_guard <= {i_cfg_data[BIT_DG_HIGH],
                                i_cfg_data[BIT_DG_LOW]};
      cfg_q.charge_guard    <= {i_cfg_data[BIT_CG_HIGH],
                                i_cfg_data[BIT_CG_LOW]};
    end
  end

  // ==========================================================
  // one-shot clear actions, live for one cycle after the write
  // the clear bits have no storage, so only the write that carries
  // them acts; a later write with them low leaves everything alone
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      clr_tallies_q <= 1'b0;
      clr_irq_q     <= 1'b0;
    end else begin
      clr_tallies_q <= i_cfg_wr & i_cfg_data[BIT_CLR_TALLIES];
      clr_irq_q     <= i_cfg_wr & i_cfg_data[BIT_CLR_IRQ];
    end
  end

  // ==========================================================
  // powerdown pin synchroniser and hard shutdown
  // only the second stage is read; the first may go metastable
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pd_sync_q <= 2'b11;
      hard_pd_q <= 1'b0;
    end else begin
      pd_sync_q <= {pd_sync_q[0], i_powerdown_pin_n};
      hard_pd_q <= ~pd_sync_q[1];
    end
  end

  // ==========================================================
  // coulomb tallies
  // a clear outranks any count in the same cycle
  // sense path is grounded in calibration, so nothing advances
  assign counting = ~cfg_q.input_zero_calibration &
                    ~cfg_q.soft_powerdown & ~hard_pd_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      chg_tally_q <= TALLY_RESET;
      dis_tally_q <= TALLY_RESET;
    end else if (clr_tallies_q) begin
      chg_tally_q <= TALLY_RESET;
      dis_tally_q <= TALLY_RESET;
    end else if (counting) begin
      if (i_tally_charge_inc) begin
        chg_tally_q <= chg_tally_q + 32'h0000_0001;
      end
      if (i_tally_discharge_inc) begin
        dis_tally_q <= dis_tally_q + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // tally read mux and select echo
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tally_read_q <= TALLY_RESET;
      echo_q       <= 1'b0;
    end else begin
      tally_read_q <= cfg_q.tally_select ? chg_tally_q
                                         : dis_tally_q;
      echo_q       <= cfg_q.tally_select;
    end
  end

  // ==========================================================
  // status flags; overcurrent not gated by calibration
  assign flag_set[3] = i_discharge_overcurrent & ~hard_pd_q;
  assign flag_set[2] = i_charge_overcurrent & ~hard_pd_q;
  assign flag_set[1] = i_compare_match & cfg_q.compare_irq_enable &
                       ~cfg_q.soft_powerdown;
  assign flag_set[0] = i_flow_reversal & ~cfg_q.soft_powerdown;
  // soft shutdown clears every flag, including flow reversal
  assign flag_clr    = {4{clr_irq_q | cfg_q.soft_powerdown}};
  // a set and a clear in one cycle leave the flag set

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      fgc_flag_latch u_flag (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_set     (flag_set[g]),
        .i_clr     (flag_clr[g]),
        .o_flag    (flag_val[g])
      );
    end
  endgenerate

  // ==========================================================
  // interrupt request from enabled flags
  // overcurrent flags always request; compare and reversal only
  // while their enable bits are set
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_val[3] | flag_val[2] |
               (flag_val[1] & cfg_q.compare_irq_enable) |
               (flag_val[0] & cfg_q.direction_irq_enable);
    end
  end

  // ==========================================================
  // analog side controls
  // each control is registered so every output leaves a flop
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      soft_pd_out_q <= 1'b0;
      zero_cal_q    <= 1'b0;
      cmp_en_q      <= 1'b0;
      dis_drive_q   <= GUARD_RESET;
      chg_drive_q   <= GUARD_RESET;
    end else begin
      soft_pd_out_q <= cfg_q.soft_powerdown;
      zero_cal_q    <= cfg_q.input_zero_calibration;
      cmp_en_q      <= cfg_q.compare_irq_enable;
      dis_drive_q   <= cfg_q.discharge_guard;
      chg_drive_q   <= cfg_q.charge_guard;
    end
  end

  assign o_zero_cal_ground        = zero_cal_q;
  assign o_soft_powerdown         = soft_pd_out_q;
  assign o_hard_powerdown         = hard_pd_q;
  assign o_compare_enable         = cmp_en_q;
  assign o_discharge_switch_drive = dis_drive_q;
  assign o_charge_switch_drive    = chg_drive_q;
  assign o_tally_read             = tally_read_q;
  assign o_flags                  = fgc_flags_t'(flag_val);
  assign o_tally_select_echo      = echo_q;
  assign o_irq                    = irq_q;

endmodule : fgc_config_word

// ===== rtl/fgc_pkg.sv
// package: configuration word layout, reset values and carriers
package fgc_pkg;

  // ==========================================================
  // configuration word field positions
  localparam int unsigned CFG_W            = 16;
  localparam int unsigned BIT_DIR_IRQ_EN   = 10;
  localparam int unsigned BIT_SOFT_PD      = 9;
  localparam int unsigned BIT_CLR_TALLIES  = 8;
  localparam int unsigned BIT_CLR_IRQ      = 7;
  localparam int unsigned BIT_TALLY_SEL    = 6;
  localparam int unsigned BIT_ZERO_CAL     = 5;
  localparam int unsigned BIT_CMP_IRQ_EN   = 4;
  localparam int unsigned BIT_DG_HIGH      = 3;
  localparam int unsigned BIT_DG_LOW       = 2;
  localparam int unsigned BIT_CG_HIGH      = 1;
  localparam int unsigned BIT_CG_LOW       = 0;

  // ==========================================================
  // reset values
  localparam logic [CFG_W-1:0] CFG_RESET   = 16'h0000;
  localparam logic [1:0]       GUARD_RESET = 2'h0;
  localparam int unsigned      TALLY_W     = 32;
  localparam logic [TALLY_W-1:0] TALLY_RESET = 32'h0000_0000;

  // ==========================================================
  // stored configuration state
  typedef struct packed {
    logic       direction_irq_enable;
    logic       soft_powerdown;
    logic       tally_select;
    logic       input_zero_calibration;
    logic       compare_irq_enable;
    logic [1:0] discharge_guard;  // {high, low}
    logic [1:0] charge_guard;     // {high, low}
  } fgc_cfg_t;

  // latched status flags
  typedef struct packed {
    logic discharge_overcurrent_flag;
    logic charge_overcurrent_flag;
    logic compare_match_flag;
    logic flow_reversal_flag;
  } fgc_flags_t;

endpackage : fgc_pkg

// ===== rtl/fgc_flag_latch.sv
// one sticky status flag with set-wins-over-clear
`timescale 1ns/1ps
module fgc_flag_latch (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // event and clear
  input  wire logic i_set,
  input  wire logic i_clr,
  // flag
  output logic      o_flag
);
  import fgc_pkg::*;

  logic flag_q;

  // ==========================================================
  // latch
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else if (i_set) begin
      flag_q <= 1'b1;
    end else if (i_clr) begin
      flag_q <= 1'b0;
    end
  end

  assign o_flag = flag_q;

endmodule : fgc_flag_latch

// ===== tb/fgc_cfg_assertions.sv
// checker: timing properties of the configuration word bank
`timescale 1ns/1ps
module fgc_cfg_assertions (
  // clock and reset
  input wire logic                        i_sys_clk,
  input wire logic                        i_rst_n,
  // inputs
  input wire logic                        i_cfg_wr,
  input wire logic [fgc_pkg::CFG_W-1:0]   i_cfg_data,
  input wire logic                        i_powerdown_pin_n,
  input wire logic                        i_tally_charge_inc,
  input wire logic                        i_tally_discharge_inc,
  input wire logic                        i_discharge_overcurrent,
  input wire logic                        i_charge_overcurrent,
  input wire logic                        i_compare_match,
  input wire logic                        i_flow_reversal,
  // outputs
  input wire logic                        o_zero_cal_ground,
  input wire logic                        o_soft_powerdown,
  input wire logic                        o_hard_powerdown,
  input wire logic                        o_compare_enable,
  input wire logic [1:0]                  o_discharge_switch_drive,
  input wire logic [1:0]                  o_charge_switch_drive,
  input wire logic [fgc_pkg::TALLY_W-1:0] o_tally_read,
  input wire fgc_pkg::fgc_flags_t         o_flags,
  input wire logic                        o_tally_select_echo
);
  import fgc_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // properties
  select_echo_a: assert property (
    i_cfg_wr |-> ##2 o_tally_select_echo == $past(i_cfg_data[6], 2))
    else $error("select echo wrong");
  mode_level_a: assert property (
    i_cfg_wr |-> ##2 {o_soft_powerdown, o_zero_cal_ground, o_compare_enable}
      == {$past(i_cfg_data[9], 2), $past(i_cfg_data[5:4], 2)})
    else $error("mode level wrong");
  guard_drive_a: assert property (
    i_cfg_wr |-> ##2 {o_discharge_switch_drive, o_charge_switch_drive}
      == $past(i_cfg_data[3:0], 2)) else $error("guard drive wrong");
  flag_clear_a: assert property (
    i_cfg_wr && i_cfg_data[7] ##1 !(i_discharge_overcurrent ||
      i_charge_overcurrent || i_compare_match || i_flow_reversal)
    |=> o_flags == 4'h0) else $error("flags not cleared");
  tally_clear_a: assert property (
    i_cfg_wr && i_cfg_data[8] ##1 !(i_tally_charge_inc ||
      i_tally_discharge_inc) |-> ##2 o_tally_read == '0)
    else $error("tally not cleared");
  hard_pd_a: assert property (
    !i_powerdown_pin_n [*3] |=> o_hard_powerdown)
    else $error("hard shutdown late");
  oc_set_a: assert property (
    i_charge_overcurrent && !o_soft_powerdown && !o_hard_powerdown &&
    !$past(i_cfg_wr) && i_powerdown_pin_n && $past(i_powerdown_pin_n) &&
    $past(i_powerdown_pin_n, 2) |=> o_flags[2])
    else $error("overcurrent flag missed");
  cal_hold_a: assert property (
    o_zero_cal_ground && !$past(i_cfg_wr) && !$past(i_cfg_wr, 2) &&
    !$past(i_cfg_wr, 3) |=> $stable(o_tally_read))
    else $error("tally moved in calibration");
  rev_clear_a: assert property (
    o_soft_powerdown && !$past(i_cfg_wr) && !$past(i_cfg_wr, 2)
    |-> !o_flags[0]) else $error("reversal flag in powerdown");
endmodule : fgc_cfg_assertions

bind fgc_config_word fgc_cfg_assertions u_chk (.*);

// ===== tb/fgc_host_model.sv
// partner model: host that loads the configuration word
`timescale 1ns/1ps
module fgc_host_model (
  // clock
  input  wire logic                    i_sys_clk,
  // word write toward the bank
  output logic                         o_cfg_wr,
  output logic [fgc_pkg::CFG_W-1:0]    o_cfg_data
);
  import fgc_pkg::*;
  initial begin
    o_cfg_wr = 1'b0;
    o_cfg_data = '0;
  end
  // whole word per command; data is driven to the inverted word once the strobe drops
  task write_word(input logic [CFG_W-1:0] w);
    @(posedge i_sys_clk);
    o_cfg_wr <= 1'b1;
    o_cfg_data <= w;
    @(posedge i_sys_clk);
    o_cfg_wr <= 1'b0;
    o_cfg_data <= ~w;
  endtask : write_word
  // calibration entry drives both switch fields to 2'b10
  task start_cal(input logic [11:0] upper);
    write_word({upper, 4'hA});
  endtask : start_cal
endmodule : fgc_host_model

// ===== tb/tb.sv
// testbench: configuration word bank scenarios
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  import fgc_pkg::*;
  logic               i_sys_clk, i_rst_n, pin_n, wr, zc, sp, hp, ce, echo, irq;
  logic [5:0]         ev, ev_mask;
  int                 ev_left = 0;
  assign ev = (ev_left != 0) ? ev_mask : 6'h00;
  logic [CFG_W-1:0]   wd;
  logic [1:0]         dsw, csw;
  logic [TALLY_W-1:0] tr;
  fgc_flags_t         fl;
  int                 error_cnt, n_tests, cycles;
  fgc_host_model u_host (.i_sys_clk(i_sys_clk), .o_cfg_wr(wr), .o_cfg_data(wd));
  fgc_config_word u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_cfg_wr(wr), .i_cfg_data(wd), .i_powerdown_pin_n(pin_n),
    .i_tally_charge_inc(ev[5]), .i_tally_discharge_inc(ev[4]),
    .i_discharge_overcurrent(ev[3]), .i_charge_overcurrent(ev[2]),
    .i_compare_match(ev[1]), .i_flow_reversal(ev[0]),
    .o_zero_cal_ground(zc), .o_soft_powerdown(sp), .o_hard_powerdown(hp),
    .o_compare_enable(ce), .o_discharge_switch_drive(dsw),
    .o_charge_switch_drive(csw), .o_tally_read(tr), .o_flags(fl),
    .o_tally_select_echo(echo), .o_irq(irq));
  task settle(input int n);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask : settle
  task pulse(input logic [5:0] m, input int n);
    @(posedge i_sys_clk);
    ev_mask <= m;
    ev_left <= n;
    repeat (n) begin
      @(posedge i_sys_clk);
      ev_left <= ev_left - 1;
    end
  endtask : pulse
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // scenarios
  task t_fields;
    logic [CFG_W-1:0] w;
    for (int b = 0; b <= 10; b++) begin
      w = 16'hF800 | (16'h0001 << b);
      u_host.write_word(w);
      settle(3);
      `CHK("fields", {w[9], w[6:0]}, {sp, echo, zc, ce, dsw, csw})
    end
  endtask : t_fields
  task t_tally;
    u_host.write_word(16'h0040);
    pulse(6'h20, 3);
    settle(4);
    `CHK("charge tally", 32'h0000_0003, tr)
    u_host.start_cal(12'h006);
    pulse(6'h3C, 3);
    settle(4);
    `CHK("cal tally", 32'h0000_0003, tr)
    `CHK("cal out", {1'b1, 4'hA, 4'hC}, {zc, dsw, csw, fl})
    u_host.write_word(16'h01C0);
    settle(4);
    `CHK("cleared", 36'h0_0000_0000, {fl, tr})
    u_host.write_word(16'h0040);
    pulse(6'h20, 1);
    settle(4);
    `CHK("one shot", 32'h0000_0001, tr)
    u_host.write_word(16'h0000);
    pulse(6'h10, 2);
    settle(4);
    `CHK("discharge tally", 32'h0000_0002, tr)
  endtask : t_tally
  task t_irq;
    pulse(6'h02, 1);
    settle(3);
    `CHK("cmp off", 5'h00, {fl, irq})
    u_host.write_word(16'h0410);
    pulse(6'h03, 1);
    settle(3);
    `CHK("irq on", 5'h07, {fl, irq})
    u_host.write_word(16'h0200);
    settle(3);
    `CHK("soft pd", 5'h10, {sp, fl})
    u_host.write_word(16'h0000);
    pulse(6'h01, 1);
    settle(3);
    `CHK("rev no irq", 5'h02, {fl, irq})
    @(posedge i_sys_clk);
    pin_n <= 1'b0;
    settle(4);
    `CHK("hard pd", 1'b1, hp)
    @(posedge i_sys_clk);
    pin_n <= 1'b1;
    settle(4);
    `CHK("hard exit", 1'b0, hp)
  endtask : t_irq
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    pin_n = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    settle(0);
    `CHK("reset", 46'h0, {zc, sp, hp, ce, dsw, csw, echo, irq, fl, tr})
    t_fields();
    t_tally();
    t_irq();
    wrap_up();
  end
endmodule : tb
